/* inc/dmi_pkg.sv */
// Timing constants and helpers for the 16K x 8 DRAM module controller.
// Assumes a single 250 MHz clock; all pin timing is counted in its cycles.
package dmi_pkg;
    // ----------------------------------------
    // Clock and geometry
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int DATA_W = 8;
    localparam int ROW_W = 8;
    localparam int COL_W = 6;
    localparam int PIN_ADDR_W = 8;
    localparam int SYNC_STAGES = 2;

    // Least time: round up, at least one cycle
    function automatic int cyc_min(input int t_ns);
        int c;
        c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Longest time: round down, at least one cycle
    function automatic int cyc_max(input int t_ns);
        int c;
        c = (t_ns * 1000) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // ----------------------------------------
    // Pin timing
    // ----------------------------------------
    localparam int T_RP_NS = 80;
    localparam int T_RCD_NS = 25;
    localparam int T_RCD_MAX_NS = 50;
    localparam int T_RAH_NS = 20;
    localparam int T_CAC_NS = 70;
    localparam int T_CP_NS = 40;
    localparam int T_RAS_MAX_NS = 10000;
    localparam int T_RWC_NS = 315;
    localparam int T_WCS_NS = -5;
    localparam int T_REF_MS = 4;
    localparam int REF_ROWS = 256;
    localparam int T_INIT_US = 100;
    localparam int INIT_CYCLES = 8;

    localparam int RP_CYC = cyc_min(T_RP_NS);
    localparam int RCD_CYC = cyc_min(T_RCD_NS);
    localparam int RAH_CYC = cyc_min(T_RAH_NS);
    // Column strobe stays low until read data has crossed the synchroniser
    localparam int CAS_LOW_CYC = cyc_min(T_CAC_NS) + SYNC_STAGES + 1;
    localparam int CP_CYC = cyc_min(T_CP_NS);
    localparam int RAS_MAX_CYC = cyc_max(T_RAS_MAX_NS);
    localparam int RWC_CYC = cyc_min(T_RWC_NS);
    localparam int RAS_HOLD_CYC = RWC_CYC - RP_CYC;
    localparam int PAGE_GUARD_CYC = CP_CYC + CAS_LOW_CYC + 2;
    localparam int INIT_WAIT_CYC = cyc_min(T_INIT_US * 1000);
    // Timer fires early enough that the longest open page still lets
    // the refresh land inside its slot
    localparam int REF_INT_CYC = cyc_max(T_REF_MS * 1000000 / REF_ROWS)
                                 - RAS_MAX_CYC - RWC_CYC;
endpackage

/* core/dmi_refresh.sv */
// Refresh scheduler: raises a pending request at a fixed interval and
// walks the refresh row. Assumes done pulses once per finished refresh.
`timescale 1ns/1ps
module dmi_refresh #(
    parameter int INTERVAL_CYC = dmi_pkg::REF_INT_CYC,
    parameter int ROW_W = dmi_pkg::ROW_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic done,
    output logic pending,
    output logic [ROW_W-1:0] row
);
    localparam int CW = $clog2(INTERVAL_CYC + 1);

    // Compare against the per-row slot; the whole period in ps overflows an int
    if (INTERVAL_CYC < 1 || INTERVAL_CYC >
        dmi_pkg::cyc_max(dmi_pkg::T_REF_MS * 1000000 / dmi_pkg::REF_ROWS)) begin : bad_interval
        $error("Refresh interval cannot cover all rows");
    end

    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic pend_ff, nxt_pend;
    logic [ROW_W-1:0] row_ff, nxt_row;
    logic tick;

    // ----------------------------------------
    // Interval timer and row pointer
    // ----------------------------------------
    always_comb begin
        tick = enable && (cnt_ff == CW'(INTERVAL_CYC - 1));
        nxt_cnt = (!enable || tick) ? '0 : cnt_ff + CW'(1);
        // A tick in the clearing cycle is kept
        nxt_pend = tick || (pend_ff && !done);
        nxt_row = done ? row_ff + ROW_W'(1) : row_ff;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= '0;
            pend_ff <= 1'b0;
            row_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
            pend_ff <= nxt_pend;
            row_ff <= nxt_row;
        end
    end

    assign pending = pend_ff;
    assign row = row_ff;
endmodule

/* core/dmi_ctrl.sv */
// Host-side controller for a 16K x 8 multiplexed-address DRAM module.
// Assumes the module pins sit outside the clock domain; read data is
// resynchronised before use. One request at a time, no queue.
`timescale 1ns/1ps
module dmi_ctrl #(
    parameter int INIT_WAIT_CYC = dmi_pkg::INIT_WAIT_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [dmi_pkg::ROW_W+dmi_pkg::COL_W-1:0] req_addr,
    input wire logic [dmi_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [dmi_pkg::DATA_W-1:0] rsp_rdata,
    output logic init_done,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [dmi_pkg::PIN_ADDR_W-1:0] muxed_address_lines,
    output logic [dmi_pkg::DATA_W-1:0] shared_data_lines_out,
    output logic shared_data_lines_oe,
    input wire logic [dmi_pkg::DATA_W-1:0] shared_data_lines_in
);
    localparam int RW = dmi_pkg::ROW_W;
    localparam int CLW = dmi_pkg::COL_W;
    localparam int DW = dmi_pkg::DATA_W;
    localparam int AW = dmi_pkg::PIN_ADDR_W;
    localparam int CNT_W = $clog2(INIT_WAIT_CYC + dmi_pkg::RAS_MAX_CYC + 1);
    localparam int RCW = $clog2(dmi_pkg::RAS_MAX_CYC + 1);

    if (INIT_WAIT_CYC < 1 || dmi_pkg::RCD_CYC <= dmi_pkg::RAH_CYC ||
        dmi_pkg::RAS_HOLD_CYC + dmi_pkg::PAGE_GUARD_CYC > dmi_pkg::RAS_MAX_CYC)
    begin : bad_cfg
        $error("Controller timing cannot be met");
    end

    typedef enum logic [7:0] {
        S_INIT = 8'h01,
        S_IDLE = 8'h02,
        S_ASU  = 8'h04,
        S_RCD  = 8'h08,
        S_CAS  = 8'h10,
        S_PAGE = 8'h20,
        S_CP   = 8'h40,
        S_PRE  = 8'h80
    } dmi_state_type;

    // Row on all lines, column on lines one to six
    function automatic logic [AW-1:0] col_pins(input logic [CLW-1:0] c);
        return {1'b0, c, 1'b0};
    endfunction

    // ----------------------------------------
    // Read data synchroniser
    // ----------------------------------------
    logic [DW-1:0] dq_s1_ff, dq_s2_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dq_s1_ff <= '0;
            dq_s2_ff <= '0;
        end else begin
            dq_s1_ff <= shared_data_lines_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // ----------------------------------------
    // Refresh scheduler
    // ----------------------------------------
    logic ref_pending, ref_done;
    logic [RW-1:0] ref_row;
    logic init_ff, nxt_init;

    dmi_refresh #(
        .INTERVAL_CYC(dmi_pkg::REF_INT_CYC),
        .ROW_W(RW)
    ) u_refresh (
        .clk(clk),
        .reset_n(reset_n),
        .enable(init_ff),
        .done(ref_done),
        .pending(ref_pending),
        .row(ref_row)
    );

    // ----------------------------------------
    // Access sequencer
    // ----------------------------------------
    dmi_state_type st_ff, nxt_st;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [RCW-1:0] rlow_ff, nxt_rlow;
    logic [3:0] icnt_ff, nxt_icnt;
    logic is_ref_ff, nxt_is_ref;
    logic wr_ff, nxt_wr;
    logic [RW-1:0] row_ff, nxt_row;
    logic [CLW-1:0] col_ff, nxt_col;
    logic ras_ff, nxt_ras, cas_ff, nxt_cas, we_ff, nxt_we;
    logic [AW-1:0] addr_ff, nxt_addr;
    logic [DW-1:0] dout_ff, nxt_dout, rdata_ff, nxt_rdata;
    logic oe_ff, nxt_oe, rsp_ff, nxt_rsp;
    logic page_ok, idle_ok;

    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        nxt_rlow = ras_ff ? '0 : rlow_ff + RCW'(1);
        nxt_icnt = icnt_ff;
        nxt_init = init_ff;
        nxt_is_ref = is_ref_ff;
        nxt_wr = wr_ff;
        nxt_row = row_ff;
        nxt_col = col_ff;
        nxt_ras = ras_ff;
        nxt_cas = cas_ff;
        nxt_we = we_ff;
        nxt_addr = addr_ff;
        nxt_dout = dout_ff;
        nxt_rdata = rdata_ff;
        nxt_oe = oe_ff;
        nxt_rsp = 1'b0;
        ref_done = 1'b0;
        idle_ok = init_ff && !ref_pending;
        // Leave room for one more column access before the row limit
        page_ok = idle_ok && req_valid && (req_addr[RW+CLW-1:CLW] == row_ff) &&
                  (rlow_ff < RCW'(dmi_pkg::RAS_MAX_CYC - dmi_pkg::PAGE_GUARD_CYC));
        req_ready = 1'b0;
        case (st_ff)
            S_INIT: begin
                // Row strobe held high through the power-up wait
                if (cnt_ff == CNT_W'(INIT_WAIT_CYC - 1)) begin
                    nxt_st = S_IDLE;
                end
            end
            S_IDLE: begin
                req_ready = idle_ok;
                if (!init_ff || ref_pending) begin
                    nxt_is_ref = 1'b1;
                    nxt_addr = ref_row;
                    nxt_st = S_ASU;
                end else if (req_valid) begin
                    nxt_is_ref = 1'b0;
                    nxt_wr = req_write;
                    nxt_row = req_addr[RW+CLW-1:CLW];
                    nxt_col = req_addr[CLW-1:0];
                    nxt_addr = req_addr[RW+CLW-1:CLW];
                    nxt_dout = req_wdata;
                    nxt_we = !req_write;
                    nxt_oe = req_write;
                    nxt_st = S_ASU;
                end
            end
            S_ASU: begin
                // Address and write enable settle a cycle before the row fall
                nxt_ras = 1'b0;
                nxt_cnt = '0;
                nxt_st = is_ref_ff ? S_PAGE : S_RCD;
            end
            S_RCD: begin
                if (cnt_ff == CNT_W'(dmi_pkg::RAH_CYC - 1)) begin
                    nxt_addr = col_pins(col_ff);
                end
                if (cnt_ff == CNT_W'(dmi_pkg::RCD_CYC - 1)) begin
                    nxt_cas = 1'b0;
                    nxt_cnt = '0;
                    nxt_st = S_CAS;
                end
            end
            S_CAS: begin
                if (cnt_ff == CNT_W'(dmi_pkg::CAS_LOW_CYC - 1)) begin
                    nxt_cas = 1'b1;
                    nxt_rdata = wr_ff ? rdata_ff : dq_s2_ff;
                    nxt_rsp = !wr_ff;
                    nxt_st = S_PAGE;
                end
            end
            S_PAGE: begin
                req_ready = !is_ref_ff && page_ok;
                if (!is_ref_ff && page_ok) begin
                    nxt_wr = req_write;
                    nxt_col = req_addr[CLW-1:0];
                    nxt_addr = col_pins(req_addr[CLW-1:0]);
                    nxt_dout = req_wdata;
                    nxt_we = !req_write;
                    nxt_oe = req_write;
                    nxt_cnt = '0;
                    nxt_st = S_CP;
                end else if (rlow_ff >= RCW'(dmi_pkg::RAS_HOLD_CYC - 1)) begin
                    // Long row-low time keeps every cycle at the full length
                    nxt_ras = 1'b1;
                    nxt_we = 1'b1;
                    nxt_oe = 1'b0;
                    nxt_cnt = '0;
                    ref_done = is_ref_ff;
                    if (is_ref_ff && !init_ff) begin
                        nxt_icnt = icnt_ff + 4'd1;
                        nxt_init = (icnt_ff == 4'(dmi_pkg::INIT_CYCLES - 1));
                    end
                    nxt_st = S_PRE;
                end
            end
            S_CP: begin
                if (cnt_ff == CNT_W'(dmi_pkg::CP_CYC - 1)) begin
                    nxt_cas = 1'b0;
                    nxt_cnt = '0;
                    nxt_st = S_CAS;
                end
            end
            S_PRE: begin
                if (cnt_ff == CNT_W'(dmi_pkg::RP_CYC - 2)) begin
                    nxt_st = S_IDLE;
                end
            end
            default: begin
                nxt_st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= S_INIT;
            cnt_ff <= '0;
            rlow_ff <= '0;
            icnt_ff <= '0;
            init_ff <= 1'b0;
            is_ref_ff <= 1'b0;
            wr_ff <= 1'b0;
            row_ff <= '0;
            col_ff <= '0;
            ras_ff <= 1'b1;
            cas_ff <= 1'b1;
            we_ff <= 1'b1;
            addr_ff <= '0;
            dout_ff <= '0;
            rdata_ff <= '0;
            oe_ff <= 1'b0;
            rsp_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            rlow_ff <= nxt_rlow;
            icnt_ff <= nxt_icnt;
            init_ff <= nxt_init;
            is_ref_ff <= nxt_is_ref;
            wr_ff <= nxt_wr;
            row_ff <= nxt_row;
            col_ff <= nxt_col;
            ras_ff <= nxt_ras;
            cas_ff <= nxt_cas;
            we_ff <= nxt_we;
            addr_ff <= nxt_addr;
            dout_ff <= nxt_dout;
            rdata_ff <= nxt_rdata;
            oe_ff <= nxt_oe;
            rsp_ff <= nxt_rsp;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Eight data lines make one word; both halves share strobes
    assign shared_data_lines_out = dout_ff;
    assign shared_data_lines_oe = oe_ff;
    assign ras_n = ras_ff;
    assign cas_n = cas_ff;
    assign we_n = we_ff;
    assign muxed_address_lines = addr_ff;
    assign rsp_valid = rsp_ff;
    assign rsp_rdata = rdata_ff;
    assign init_done = init_ff;
endmodule

/* dv/dmi_ctrl_assertions.sv */
// Concurrent checks on the DRAM pin timing that dmi_ctrl produces.
// Assumes one clock domain; bound onto every dmi_ctrl instance below.
`timescale 1ns/1ps
module dmi_ctrl_checker #(
    parameter int INIT_WAIT_CYC = dmi_pkg::INIT_WAIT_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_ready,
    input wire logic init_done,
    input wire logic rsp_valid,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [dmi_pkg::PIN_ADDR_W-1:0] muxed_address_lines,
    input wire logic shared_data_lines_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    // Counters saturate so that long idle spans cannot wrap into false fails
    logic ras_q_ff, nxt_ras_q, fall;
    logic [11:0] low_ff, nxt_low;
    logic [15:0] high_ff, nxt_high;
    logic [6:0] cyc_ff, nxt_cyc;
    logic [3:0] cash_ff, nxt_cash, falls_ff, nxt_falls;
    always_comb begin
        fall = ras_q_ff & ~ras_n;
        nxt_ras_q = ras_n;
        nxt_low = ras_n ? 12'h000 : low_ff + 12'(low_ff != 12'hfff);
        nxt_high = !ras_n ? 16'h0000 : high_ff + 16'(high_ff != 16'hffff);
        nxt_cyc = fall ? 7'h01 : cyc_ff + 7'(cyc_ff != 7'h7f);
        nxt_cash = !cas_n ? 4'h0 : cash_ff + 4'(cash_ff != 4'hf);
        nxt_falls = falls_ff + 4'(fall && falls_ff != 4'hf);
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ras_q_ff <= 1'b1;
            low_ff <= 12'h000;
            high_ff <= 16'h0000;
            cyc_ff <= 7'h7f;
            cash_ff <= 4'hf;
            falls_ff <= 4'h0;
        end else begin
            ras_q_ff <= nxt_ras_q;
            low_ff <= nxt_low;
            high_ff <= nxt_high;
            cyc_ff <= nxt_cyc;
            cash_ff <= nxt_cash;
            falls_ff <= nxt_falls;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_ras_max; !ras_n |-> low_ff < 12'h9c4; endproperty
    a_ras_max: assert property (p_ras_max) else $error("row strobe low too long");
    property p_ras_pre; $fell(ras_n) |-> high_ff >= 16'h0014; endproperty
    a_ras_pre: assert property (p_ras_pre) else $error("row precharge short");
    property p_cycle; $fell(ras_n) |-> cyc_ff >= 7'h4f; endproperty
    a_cycle: assert property (p_cycle) else $error("row cycle short");
    property p_init_wait;
        $fell(ras_n) && falls_ff == 4'h0 |-> high_ff >= INIT_WAIT_CYC;
    endproperty
    a_init_wait: assert property (p_init_wait) else $error("power-up wait short");
    property p_init_cnt; $rose(init_done) |-> falls_ff >= 4'h8; endproperty
    a_init_cnt: assert property (p_init_cnt) else $error("too few init cycles");
    property p_ready; req_ready |-> init_done; endproperty
    a_ready: assert property (p_ready) else $error("ready before init");
    property p_rcd; $fell(cas_n) |-> !ras_n && low_ff >= 12'h007; endproperty
    a_rcd: assert property (p_rcd) else $error("column fall too early");
    property p_cp; $fell(cas_n) |-> cash_ff >= 4'ha; endproperty
    a_cp: assert property (p_cp) else $error("column precharge short");
    property p_cs; !cas_n |-> !ras_n; endproperty
    a_cs: assert property (p_cs) else $error("column strobe without row");
    property p_col;
        $fell(cas_n) |-> muxed_address_lines[7] == 1'b0 && muxed_address_lines[0] == 1'b0;
    endproperty
    a_col: assert property (p_col) else $error("column on wrong lines");
    property p_addr; !cas_n || $fell(ras_n) |-> $stable(muxed_address_lines); endproperty
    a_addr: assert property (p_addr) else $error("address moved at strobe");
    property p_we; !cas_n |-> $stable(we_n); endproperty
    a_we: assert property (p_we) else $error("write enable late");
    property p_oe; $fell(cas_n) |-> shared_data_lines_oe == !we_n; endproperty
    a_oe: assert property (p_oe) else $error("data drive mismatch");
    c_read: cover property (rsp_valid);
    c_write: cover property ($fell(cas_n) && !we_n);
    c_page: cover property ($fell(cas_n) && low_ff > 12'h01e);
endmodule
bind dmi_ctrl dmi_ctrl_checker #(.INIT_WAIT_CYC(INIT_WAIT_CYC)) u_chk (
    .clk(clk), .reset_n(reset_n), .req_ready(req_ready), .init_done(init_done),
    .rsp_valid(rsp_valid), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .muxed_address_lines(muxed_address_lines), .shared_data_lines_oe(shared_data_lines_oe)
);

/* dv/dmi_dram_model.sv */
// Behavioural model of the 16K x 8 DRAM module seen from its pins.
// Assumes early writes only; the bench resolves the shared data bus.
`timescale 1ns/1ps
module dmi_dram_model #(
    parameter int ACCESS_NS = 70
) (
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] d,
    output logic [7:0] q
);
    logic [7:0] mem [16384];
    logic [7:0] row;
    logic [13:0] col_addr;
    initial begin
        foreach (mem[i]) mem[i] = 8'h5a;
        q = 8'h00;
        row = 8'h00;
    end
    // A fall with no column strobe after it is a refresh and drives nothing
    always @(negedge ras_n) row = addr;
    always @(negedge cas_n) begin
        if (!ras_n) begin
            col_addr = {row, addr[6:1]};
            if (!we_n) begin
                mem[col_addr] = d;
            end else begin
                q = ~q;
                q <= #ACCESS_NS mem[col_addr];
            end
        end
    end
    // Released bus shows the inverse, so stale data never reads as good
    always @(posedge cas_n) q = ~q;
endmodule

/* dv/dmi_ctrl_bench.sv */
// Self-checking bench for dmi_ctrl against the behavioural DRAM module.
// Assumes a shortened power-up wait so initialisation stays brief.
`timescale 1ns/1ps
module dmi_ctrl_bench;
    localparam int INIT_W = 20;
    logic clk, reset_n, req_valid, req_ready, req_write, rsp_valid, init_done;
    logic ras_n, cas_n, we_n, dq_oe;
    logic [13:0] req_addr;
    logic [7:0] req_wdata, rsp_rdata, muxed_address_lines, dq_out, mdl_q, dq_bus;
    logic [7:0] ras_falls, cas_falls;
    int error_cnt, n_compared;
    // Each row: write flag, address, write data, expected read data
    logic [30:0] rows [10];
    assign dq_bus = dq_oe ? dq_out : mdl_q;
    dmi_ctrl #(.INIT_WAIT_CYC(INIT_W)) dut (
        .clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .muxed_address_lines(muxed_address_lines),
        .shared_data_lines_out(dq_out), .shared_data_lines_oe(dq_oe),
        .shared_data_lines_in(dq_bus));
    dmi_dram_model mdl (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .addr(muxed_address_lines), .d(dq_bus), .q(mdl_q));
    always @(negedge ras_n) ras_falls++;
    always @(negedge cas_n) cas_falls++;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Request is held until ready is seen settled, mid-cycle
    task automatic access(input logic wr, input logic [13:0] a, input logic [7:0] d,
                          input logic [7:0] e);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        check("request taken", 8'(req_ready), 8'h01);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        if (!wr) begin
            n = 0;
            while (rsp_valid !== 1'b1 && n < 200) begin
                @(posedge clk);
                #1;
                n++;
            end
            check("read answer", 8'(rsp_valid), 8'h01);
            check("read data", rsp_rdata, e);
        end
    endtask
    task automatic wait_init();
        int n;
        n = 0;
        ras_falls = 8'h00;
        reset_n = 1'b1;
        while (init_done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("init done", 8'(init_done), 8'h01);
        check("init row cycles", ras_falls, 8'h08);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        error_cnt = 0;
        n_compared = 0;
        reset_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 14'h0000;
        req_wdata = 8'h00;
        cas_falls = 8'h00;
        rows = '{{1'b1, 14'h0000, 8'h11, 8'h00}, {1'b1, 14'h3fff, 8'hee, 8'h00},
                 {1'b1, 14'h0001, 8'ha5, 8'h00}, {1'b1, 14'h0040, 8'h3c, 8'h00},
                 {1'b0, 14'h0000, 8'h00, 8'h11}, {1'b0, 14'h0001, 8'h00, 8'ha5},
                 {1'b0, 14'h003f, 8'h00, 8'h5a}, {1'b0, 14'h3fff, 8'h00, 8'hee},
                 {1'b0, 14'h0040, 8'h00, 8'h3c}, {1'b0, 14'h2a95, 8'h00, 8'h5a}};
        repeat (2) @(posedge clk);
        #1;
        wait_init();
        foreach (rows[i]) begin
            access(rows[i][30], rows[i][29:16], rows[i][15:8], rows[i][7:0]);
        end
        // Idle span: only row-strobe refreshes may appear
        ras_falls = 8'h00;
        cas_falls = 8'h00;
        repeat (1500) @(posedge clk);
        #1;
        check("refresh seen", 8'(ras_falls != 8'h00), 8'h01);
        check("column falls in refresh", cas_falls, 8'h00);
        // Reset with a read in flight; the module must keep its contents
        req_valid = 1'b1;
        req_write = 1'b0;
        req_addr = 14'h0040;
        for (int n = 0; n < 200 && ras_n !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        check("row fall before reset", 8'(ras_n), 8'h00);
        #1;
        reset_n = 1'b0;
        req_valid = 1'b0;
        #1;
        check("reset pins", {1'b0, ras_n, cas_n, we_n, dq_oe, init_done, rsp_valid, req_ready},
              8'h70);
        @(posedge clk);
        #1;
        wait_init();
        access(1'b0, 14'h3fff, 8'h00, 8'hee);
        access(1'b0, 14'h0040, 8'h00, 8'h3c);
        give_verdict();
    end
endmodule
